// ---- pkg/ctsc_pkg.sv ----
// Constants and types for the capture trigger and sync control block
package ctsc_pkg;

  // Register port geometry
  localparam int unsigned DATA_W         = 16;
  localparam int unsigned ADDR_W         = 3;
  localparam int unsigned TIMER_W        = 16;

  // Register offsets
  localparam logic [2:0]  ADDR_CTRL      = 3'h0;
  localparam logic [2:0]  ADDR_IRQ_STAT  = 3'h1;
  localparam logic [2:0]  ADDR_IRQ_MASK  = 3'h2;
  localparam logic [2:0]  ADDR_TMR_LO    = 3'h3;
  localparam logic [2:0]  ADDR_TMR_HI    = 3'h4;

  // Control register fields
  localparam int unsigned BIT_CASCADE    = 8;
  localparam int unsigned BIT_TRIG_MODE  = 7;
  localparam int unsigned BIT_TRIG_STAT  = 6;
  localparam int unsigned SYNC_SEL_LSB   = 0;
  localparam int unsigned SYNC_SEL_W     = 5;
  localparam int unsigned SRC_N          = 32;
  localparam logic [15:0] CTRL_RESET     = 16'h000d;
  localparam logic [15:0] CTRL_IMPL_MASK = 16'h01df;

  // Interrupt event bits
  localparam int unsigned EV_TRIG        = 0;
  localparam int unsigned EV_SYNC        = 1;
  localparam int unsigned EV_WRAP        = 2;
  localparam int unsigned EV_N           = 3;
  localparam logic [2:0]  IRQ_RESET      = 3'h0;

  // Trigger generator outputs serving capture channels 1 to 4
  localparam int unsigned TRIG_GEN_FIRST = 8;
  localparam int unsigned TRIG_GEN_LAST  = 11;
  localparam int unsigned TRIG_GEN_N     = TRIG_GEN_LAST - TRIG_GEN_FIRST + 1;

  typedef enum logic {
    CTSC_MODE_SYNC,
    CTSC_MODE_TRIG
  } ctsc_mode_t;

endpackage

// ---- hw/ctsc_counter.sv ----
// Capture timer counter with synchronous clear, run gate and increment enable
`timescale 1ns/1ps
module ctsc_counter #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Control
  input  wire logic         clear,
  input  wire logic         run,
  input  wire logic         inc,
  // Count
  output logic [W-1:0]      count_q,
  output logic              wrap
);

  // Carry only on a real step from all ones
  assign wrap = run & inc & ~clear & (&count_q);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (clear) begin
      count_q <= '0;
    end else if (run && inc) begin
      count_q <= count_q + 1'b1;
    end
  end

endmodule

// ---- hw/ctsc_ctrl.sv ----
// Trigger and sync control for one capture channel with its register port
//
// Contract
// RULE1: Cascade set: odd and even form 32 bits
// RULE2: Cascade clear: channels run independently
// RULE3: Software sets cascade in both partners
// RULE4: Trigger mode: source event starts timer
// RULE5: Sync mode: source keeps timer aligned
// RULE6: Status one runs timer, zero holds clear
// RULE7: Selected source sets trigger status
// RULE8: Software reads, sets and clears status
// RULE9: Five-bit field selects the source
// RULE10: Channel never sources itself
// RULE11: Trigger-only sources not used for sync; code lets any selected source act in sync mode
// RULE12: One dedicated generator output per channel
// RULE13: Unimplemented control bits read zero
// RULE14: Sync event zeroes timer count
`timescale 1ns/1ps
module ctsc_ctrl #(
  parameter int unsigned CHANNEL_NUM = 1,
  parameter bit          IS_ODD      = 1'b1,
  parameter logic [4:0]  PTG_SRC_IDX = 5'h0a
) (
  // Clock and reset
  input  wire logic                                   clk_sys,
  input  wire logic                                   rst_n,
  // Register port
  input  wire logic [ctsc_pkg::ADDR_W-1:0]            reg_addr,
  input  wire logic [ctsc_pkg::DATA_W-1:0]            reg_wdata,
  input  wire logic                                   reg_wr,
  input  wire logic                                   reg_rd,
  output logic      [ctsc_pkg::DATA_W-1:0]            reg_rdata,
  // Sync and trigger sources
  input  wire logic [ctsc_pkg::SRC_N-1:0]             sync_sources,
  input  wire logic [ctsc_pkg::TRIG_GEN_N-1:0]        trig_gen_out,
  // Cascade partner
  input  wire logic                                   partner_cascade,
  input  wire logic                                   partner_run,
  input  wire logic                                   partner_clear,
  input  wire logic                                   partner_carry,
  input  wire logic [ctsc_pkg::TIMER_W-1:0]           partner_timer,
  // Cascade to partner
  output logic                                        cascade_pair_select,
  output logic                                        run_out,
  output logic                                        clear_out,
  output logic                                        carry_out,
  // Timer and status
  output logic      [ctsc_pkg::TIMER_W-1:0]           capture_timer,
  output logic                                        timer_trigger_status,
  // Interrupt
  output logic                                        irq
);

  logic [15:0]                       ctrl_q;
  logic [ctsc_pkg::EV_N-1:0]         irq_stat_q;
  logic [ctsc_pkg::EV_N-1:0]         irq_mask_q;
  logic [ctsc_pkg::SRC_N-1:0]        src_vec;
  logic [ctsc_pkg::SYNC_SEL_W-1:0]   sync_source_select;
  logic                              trigger_mode_select;
  logic                              trig_stat;
  logic                              sel_level;
  logic                              sel_prev_q;
  logic                              src_ev;
  logic                              cascade_active;
  logic                              cascade_hi;
  logic                              own_run;
  logic                              own_clear;
  logic                              tmr_run;
  logic                              tmr_clear;
  logic                              tmr_inc;
  logic                              tmr_wrap;
  logic                              ctrl_wr;
  logic                              stat_wr;
  logic                              mask_wr;
  logic [ctsc_pkg::EV_N-1:0]         ev_vec;
  logic [15:0]                       rd_mux;
  ctsc_pkg::ctsc_mode_t              mode;

  assign ctrl_wr = reg_wr & (reg_addr == ctsc_pkg::ADDR_CTRL);
  assign stat_wr = reg_wr & (reg_addr == ctsc_pkg::ADDR_IRQ_STAT);
  assign mask_wr = reg_wr & (reg_addr == ctsc_pkg::ADDR_IRQ_MASK);

  assign sync_source_select =
    ctrl_q[ctsc_pkg::SYNC_SEL_LSB +: ctsc_pkg::SYNC_SEL_W]; // RULE9
  assign trigger_mode_select = ctrl_q[ctsc_pkg::BIT_TRIG_MODE];
  assign trig_stat           = ctrl_q[ctsc_pkg::BIT_TRIG_STAT];
  assign mode = trigger_mode_select ? ctsc_pkg::CTSC_MODE_TRIG : ctsc_pkg::CTSC_MODE_SYNC;

  // Source vector: index zero means no source
  genvar gi;
  generate
    for (gi = 0; gi < ctsc_pkg::SRC_N; gi++) begin : g_src
      if (gi == 0) begin : g_none
        assign src_vec[gi] = 1'b0;
      end else if (gi == PTG_SRC_IDX) begin : g_ptg
        assign src_vec[gi] = trig_gen_out[CHANNEL_NUM-1]; // RULE12
      end else begin : g_ext
        assign src_vec[gi] = sync_sources[gi];
      end
    end
  endgenerate

  // Rising edge so a held level counts once; a select change may give one spurious edge
  assign sel_level = src_vec[sync_source_select]; // RULE9
  assign src_ev    = sel_level & ~sel_prev_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_prev_q <= 1'b0;
    end else begin
      sel_prev_q <= sel_level;
    end
  end

  // Pairing needs the bit on both partners
  assign cascade_active = ctrl_q[ctsc_pkg::BIT_CASCADE] & partner_cascade; // RULE1 RULE3
  assign cascade_hi     = cascade_active & ~IS_ODD;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= ctsc_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= reg_wdata & ctsc_pkg::CTRL_IMPL_MASK; // RULE13 RULE8
      if (src_ev) begin
        ctrl_q[ctsc_pkg::BIT_TRIG_STAT] <= 1'b1; // RULE7
      end
    end else if (src_ev) begin
      ctrl_q[ctsc_pkg::BIT_TRIG_STAT] <= 1'b1; // RULE7
    end
  end

  // Own timer control; a sync event re-zeroes a running count
  assign own_run   = trig_stat; // RULE6 RULE4
  assign own_clear = ~trig_stat |
                     (src_ev & (mode == ctsc_pkg::CTSC_MODE_SYNC)); // RULE6 RULE14 RULE5

  // Upper half follows the lower partner; otherwise standalone
  assign tmr_run   = cascade_hi ? partner_run   : own_run;   // RULE1 RULE2
  assign tmr_clear = cascade_hi ? partner_clear : own_clear; // RULE1 RULE2
  assign tmr_inc   = cascade_hi ? partner_carry : 1'b1;      // RULE1 RULE2

  ctsc_counter #(
    .W       (ctsc_pkg::TIMER_W)
  ) u_counter (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clear   (tmr_clear),
    .run     (tmr_run),
    .inc     (tmr_inc),
    .count_q (capture_timer),
    .wrap    (tmr_wrap)
  );

  // Partner signals are registered, so the upper half trails by one cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run_out   <= 1'b0;
      clear_out <= 1'b1;
      carry_out <= 1'b0;
    end else begin
      run_out   <= own_run;
      clear_out <= own_clear;
      carry_out <= tmr_wrap & ~cascade_hi;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cascade_pair_select  <= 1'b0;
      timer_trigger_status <= 1'b0;
    end else begin
      cascade_pair_select  <= ctrl_q[ctsc_pkg::BIT_CASCADE];
      timer_trigger_status <= trig_stat;
    end
  end

  // Interrupt events; set wins over a same-cycle clear
  assign ev_vec[ctsc_pkg::EV_TRIG] = src_ev & (mode == ctsc_pkg::CTSC_MODE_TRIG);
  assign ev_vec[ctsc_pkg::EV_SYNC] = src_ev & (mode == ctsc_pkg::CTSC_MODE_SYNC);
  assign ev_vec[ctsc_pkg::EV_WRAP] = tmr_wrap;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= ctsc_pkg::IRQ_RESET;
    end else if (stat_wr) begin
      irq_stat_q <= (irq_stat_q & ~reg_wdata[ctsc_pkg::EV_N-1:0]) | ev_vec;
    end else begin
      irq_stat_q <= irq_stat_q | ev_vec;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_q <= ctsc_pkg::IRQ_RESET;
    end else if (mask_wr) begin
      irq_mask_q <= reg_wdata[ctsc_pkg::EV_N-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 16'h0000;
    case (reg_addr)
      ctsc_pkg::ADDR_CTRL:     rd_mux = ctrl_q & ctsc_pkg::CTRL_IMPL_MASK; // RULE13
      ctsc_pkg::ADDR_IRQ_STAT: rd_mux = {13'h0000, irq_stat_q};
      ctsc_pkg::ADDR_IRQ_MASK: rd_mux = {13'h0000, irq_mask_q};
      ctsc_pkg::ADDR_TMR_LO:   rd_mux = capture_timer;
      ctsc_pkg::ADDR_TMR_HI:   rd_mux = (cascade_active && IS_ODD) ? partner_timer : 16'h0000;
      default:                 rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_trig_start;
    (mode == ctsc_pkg::CTSC_MODE_TRIG) && src_ev && !trig_stat && !cascade_hi && !ctrl_wr;
  endsequence

  sequence s_quiet2;
    !ctrl_wr [*2];
  endsequence

  sequence s_hi_step;
    cascade_hi && partner_run && !partner_clear && partner_carry;
  endsequence

  AST_TRIG_START: assert property ( // RULE4
    s_trig_start ##1 s_quiet2 |-> trig_stat && (capture_timer == 16'h0001))
    else $error("trigger event did not start the timer");

  AST_SYNC_ZERO: assert property ( // RULE14 RULE5
    ((mode == ctsc_pkg::CTSC_MODE_SYNC) && src_ev && !cascade_hi) |=> (capture_timer == 16'h0000))
    else $error("sync event did not zero the timer");

  AST_HELD_CLEAR: assert property ( // RULE6
    (!trig_stat && !cascade_hi) [*2] |-> (capture_timer == 16'h0000))
    else $error("timer not held clear while status is low");

  AST_HW_SET: assert property ( // RULE7
    src_ev |=> trig_stat && timer_trigger_status == $past(trig_stat))
    else $error("selected source did not set trigger status");

  AST_SW_WRITE: assert property ( // RULE8
    (ctrl_wr && !src_ev) |=> (trig_stat == $past(reg_wdata[ctsc_pkg::BIT_TRIG_STAT])))
    else $error("software write to trigger status lost");

  AST_UNIMPL_ZERO: assert property ( // RULE13
    (reg_rd && reg_addr == ctsc_pkg::ADDR_CTRL) |=>
      ((reg_rdata & ~ctsc_pkg::CTRL_IMPL_MASK) == 16'h0000))
    else $error("unimplemented control bit read as one");

  AST_CASC_STEP: assert property ( // RULE1
    s_hi_step |=> (capture_timer == $past(capture_timer) + 16'h0001))
    else $error("upper half missed a partner carry");

  AST_CASC_HOLD: assert property ( // RULE1
    (cascade_hi && partner_run && !partner_clear && !partner_carry) |=> $stable(capture_timer))
    else $error("upper half moved without a carry");

  AST_INDEPENDENT: assert property ( // RULE2
    (!cascade_active && trig_stat && !own_clear) |=>
      (capture_timer == $past(capture_timer) + 16'h0001))
    else $error("standalone timer did not count");

  AST_PTG_SRC: assert property ( // RULE12
    (sync_source_select == PTG_SRC_IDX && trig_gen_out[CHANNEL_NUM-1] && !sel_prev_q) |-> src_ev)
    else $error("dedicated generator output not seen");

  // Hardware set must survive a same-cycle software write
  AST_SET_WINS: assert property ( // RULE7
    (ctrl_wr && src_ev) |=> trig_stat)
    else $error("software write beat a same-cycle source event");

  AST_STATUS_HOLD: assert property ( // RULE8
    (!ctrl_wr && !src_ev) |=> (trig_stat == $past(trig_stat)))
    else $error("trigger status changed with no write or event");

  AST_TRIG_EVENT: assert property ( // RULE4
    ((mode == ctsc_pkg::CTSC_MODE_TRIG) && src_ev) |=> irq_stat_q[ctsc_pkg::EV_TRIG])
    else $error("trigger event not recorded");

  AST_HI_ZERO: assert property ( // RULE2
    (reg_rd && reg_addr == ctsc_pkg::ADDR_TMR_HI && !cascade_active) |=>
      (reg_rdata == 16'h0000))
    else $error("upper timer word read nonzero without cascade");

  AST_RDATA_IDLE: assert property ( // RULE13
    !reg_rd |=> (reg_rdata == 16'h0000))
    else $error("read data stood past its cycle");

endmodule

// ---- verif/ctsc_src_model.sv ----
// Far-side model: other timers, trigger generator and the even partner
`timescale 1ns/1ps
module ctsc_src_model (
  // Clock
  input  wire logic        clk_sys,
  // Sources
  output logic      [31:0] sync_sources,
  output logic      [3:0]  trig_gen_out,
  // Even partner
  output logic             partner_cascade,
  output logic             partner_run,
  output logic             partner_clear,
  output logic             partner_carry,
  output logic      [15:0] partner_timer
);
  // Sources idle low; the channel's own outputs are never fed back as a source
  initial begin
    sync_sources = 32'h0;
    trig_gen_out = 4'h0;
    partner_cascade = 1'b0;
    partner_run = 1'b0;
    partner_clear = 1'b0;
    partner_carry = 1'b0;
    partner_timer = 16'h0;
  end
  // Level held for len cycles; a long hold shows a slow source
  task automatic pulse_sync(input int idx, input int len);
    @(posedge clk_sys);
    sync_sources[idx] <= 1'b1;
    repeat (len) @(posedge clk_sys);
    sync_sources[idx] <= 1'b0;
  endtask
  task automatic pulse_gen(input int idx, input int len);
    @(posedge clk_sys);
    trig_gen_out[idx] <= 1'b1;
    repeat (len) @(posedge clk_sys);
    trig_gen_out[idx] <= 1'b0;
  endtask
  task automatic set_partner(input logic casc, input logic [15:0] tmr);
    @(posedge clk_sys);
    partner_cascade <= casc;
    partner_timer <= tmr;
  endtask
endmodule

// ---- verif/ctsc_ctrl_tb.sv ----
// Self-checking bench for the capture trigger and sync control
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module ctsc_ctrl_tb;
  logic        clk_sys;
  logic        rst_n;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [31:0] sync_sources;
  logic [3:0]  trig_gen_out;
  logic        p_casc;
  logic        p_run;
  logic        p_clr;
  logic        p_carry;
  logic [15:0] p_tmr;
  logic        cps;
  logic        tts;
  logic        irq;
  logic [15:0] capture_timer;
  logic        run_o;
  logic        clr_o;
  logic        carry_o;
  int          errors;
  int          checks_done;
  int          cycles;

  ctsc_ctrl #(.CHANNEL_NUM(1), .IS_ODD(1'b1), .PTG_SRC_IDX(5'h0a)) u_ctsc_ctrl (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sync_sources(sync_sources), .trig_gen_out(trig_gen_out),
    .partner_cascade(p_casc), .partner_run(p_run), .partner_clear(p_clr),
    .partner_carry(p_carry), .partner_timer(p_tmr), .cascade_pair_select(cps),
    .run_out(run_o), .clear_out(clr_o), .carry_out(carry_o), .capture_timer(capture_timer),
    .timer_trigger_status(tts), .irq(irq));

  ctsc_src_model u_ctsc_src_model (
    .clk_sys(clk_sys), .sync_sources(sync_sources), .trig_gen_out(trig_gen_out),
    .partner_cascade(p_casc), .partner_run(p_run), .partner_clear(p_clr),
    .partner_carry(p_carry), .partner_timer(p_tmr));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // The full timer wrap alone takes about 65.5k cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 70000) begin
      errors++;
      finish_test();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, exp)
  endtask

  task automatic t_reset();
    rd(ctsc_pkg::ADDR_CTRL, ctsc_pkg::CTRL_RESET);
    rd(ctsc_pkg::ADDR_IRQ_STAT, 16'h0000);
    rd(ctsc_pkg::ADDR_IRQ_MASK, 16'h0000);
    rd(3'h7, 16'h0000);
    `CHK(capture_timer, 16'h0000)
  endtask

  task automatic t_soft();
    wr(ctsc_pkg::ADDR_CTRL, 16'hffff);
    rd(ctsc_pkg::ADDR_CTRL, 16'h01df);
    wr(ctsc_pkg::ADDR_CTRL, 16'h0000);
    wr(3'h6, 16'hffff);
    rd(ctsc_pkg::ADDR_CTRL, 16'h0000);
    tick(1);
    `CHK(tts, 1'b0)
    `CHK(capture_timer, 16'h0000)
    `CHK(run_o, 1'b0)
    `CHK(clr_o, 1'b1)
    wr(ctsc_pkg::ADDR_CTRL, 16'h0040);
    tick(1);
    `CHK(tts, 1'b1)
    `CHK(run_o, 1'b1)
    `CHK(clr_o, 1'b0)
    `CHK(capture_timer, 16'h0001)
    tick(5);
    `CHK(capture_timer, 16'h0006)
  endtask

  task automatic t_trigger();
    wr(ctsc_pkg::ADDR_CTRL, 16'h0083);
    wr(ctsc_pkg::ADDR_IRQ_STAT, 16'h0007);
    u_ctsc_src_model.pulse_sync(4, 1);
    tick(3);
    `CHK(tts, 1'b0)
    u_ctsc_src_model.pulse_sync(3, 3);
    tick(3);
    `CHK(capture_timer, 16'h0005)
    rd(ctsc_pkg::ADDR_CTRL, 16'h00c3);
    rd(ctsc_pkg::ADDR_IRQ_STAT, 16'h0001);
    `CHK(irq, 1'b0)
    wr(ctsc_pkg::ADDR_IRQ_MASK, 16'h0001);
    tick(1);
    `CHK(irq, 1'b1)
    wr(ctsc_pkg::ADDR_IRQ_STAT, 16'h0001);
    tick(1);
    `CHK(irq, 1'b0)
  endtask

  // Held-high source must re-zero only once
  task automatic t_sync();
    wr(ctsc_pkg::ADDR_CTRL, 16'h0043);
    tick(10);
    u_ctsc_src_model.pulse_sync(3, 3);
    tick(3);
    `CHK(capture_timer, 16'h0005)
    rd(ctsc_pkg::ADDR_IRQ_STAT, 16'h0002);
    // Event and a status-clearing write on one edge: the event wins
    fork
      u_ctsc_src_model.pulse_sync(3, 1);
      wr(ctsc_pkg::ADDR_CTRL, 16'h0003);
    join
    tick(1);
    `CHK(tts, 1'b1)
  endtask

  task automatic t_select();
    for (int i = 1; i < 32; i++) begin
      if (i != 10) begin
        wr(ctsc_pkg::ADDR_CTRL, 16'(i));
        u_ctsc_src_model.pulse_sync(i, 1);
        tick(2);
        `CHK(tts, 1'b1)
      end
    end
    wr(ctsc_pkg::ADDR_CTRL, 16'h0000);
    u_ctsc_src_model.pulse_sync(0, 1);
    tick(2);
    `CHK(tts, 1'b0)
    wr(ctsc_pkg::ADDR_CTRL, 16'h000a);
    u_ctsc_src_model.pulse_sync(10, 1);
    u_ctsc_src_model.pulse_gen(1, 1);
    tick(2);
    `CHK(tts, 1'b0)
    u_ctsc_src_model.pulse_gen(0, 1);
    tick(2);
    `CHK(tts, 1'b1)
  endtask

  task automatic t_cascade();
    u_ctsc_src_model.set_partner(1'b0, 16'h1234);
    wr(ctsc_pkg::ADDR_CTRL, 16'h0100);
    rd(ctsc_pkg::ADDR_TMR_HI, 16'h0000);
    u_ctsc_src_model.set_partner(1'b1, 16'h1234);
    rd(ctsc_pkg::ADDR_TMR_HI, 16'h1234);
    `CHK(cps, 1'b1)
    wr(ctsc_pkg::ADDR_CTRL, 16'h0000);
    rd(ctsc_pkg::ADDR_TMR_HI, 16'h0000);
  endtask

  // Full count of the timer; carry stands for one cycle only
  task automatic t_wrap();
    wr(ctsc_pkg::ADDR_IRQ_STAT, 16'h0007);
    wr(ctsc_pkg::ADDR_CTRL, 16'h0040);
    tick(65535);
    `CHK(capture_timer, 16'hffff)
    `CHK(carry_o, 1'b0)
    tick(1);
    `CHK(capture_timer, 16'h0000)
    `CHK(carry_o, 1'b1)
    tick(1);
    `CHK(carry_o, 1'b0)
    rd(ctsc_pkg::ADDR_TMR_LO, 16'h0002);
    rd(ctsc_pkg::ADDR_IRQ_STAT, 16'h0004);
  endtask

  initial begin
    errors = 0;
    checks_done = 0;
    cycles = 0;
    rst_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_soft();
    t_trigger();
    t_sync();
    t_select();
    t_cascade();
    t_wrap();
    finish_test();
  end
endmodule
